// *** design/fmr_defs.vh ***
`ifndef FMR_DEFS_VH
`define FMR_DEFS_VH

// ----------------------------------------
// Register numbers of the map
// ----------------------------------------
`define FMR_VS_BASE 16'h01e0
`define FMR_VS_STRIDE 16'h002a
`define FMR_VS_LAST 16'h025e
`define FMR_FR_BASE 16'h0288
`define FMR_FR_END 16'h02d0
`define FMR_BARO 16'h0330
`define FMR_CG_BASE 16'h0332
`define FMR_CG_TMO 16'h035e
`define FMR_DT_BASE 16'h035f
`define FMR_DT_END 16'h0364
`define FMR_PS_BASE 16'h0366
`define FMR_PS_STRIDE 16'h0036
`define FMR_PS_LAST 16'h04e0
`define FMR_PS_END 16'h0516

// ----------------------------------------
// Word offsets inside blocks
// ----------------------------------------
`define FMR_VS_RATE_END 6'h06
`define FMR_VS_TOT_OFS 6'h06
`define FMR_VS_TOT_END 6'h0c
`define FMR_VS_PREM_OFS 6'h18
`define FMR_VS_PREM_END 6'h1e
`define FMR_PS_TMO_OFS 6'h34
`define FMR_PS_UNUSED 6'h35
`define FMR_CG_WORDS 6'h2c

// ----------------------------------------
// Read-write store layout (index from FMR_BARO)
// ----------------------------------------
`define FMR_RW_WORDS 486
`define FMR_RW_CG_IDX 9'h002
`define FMR_RW_PS_IDX 9'h036

// ----------------------------------------
// Totals, float and source codes
// ----------------------------------------
`define FMR_TOTAL_WRAP 26'h0989680
`define FMR_FLOAT_BIAS 8'h7f
`define FMR_SRC_KEYPAD 2'h0
`define FMR_SRC_COMMON 2'h1
`define FMR_SRC_STREAM 2'h2
`define FMR_TMO_MAX 16'hffff
`define FMR_TMO_RESET 16'h0000

`endif

// *** design/fmr_int_to_float.v ***
`timescale 1ns/100ps
`include "fmr_defs.vh"

// --------------------
// Unsigned integer to single precision
// --------------------
module fmr_int_to_float (
    value,
    result
);
    input wire [23:0] value;  // Whole number below 2^24
    output reg [31:0] result; // Sign, biased exponent, fraction

    integer i;
    reg [4:0] lead;     // Position of the leading one
    reg [23:0] norm;    // Value shifted so the leading one is bit 23

    // Leading one search, then normalise
    always @* begin
        lead = 5'h00;
        norm = 24'h000000;
        for (i = 0; i < 24; i = i + 1) begin
            if (value[i]) begin
                lead = i[4:0];
            end
        end
        norm = value << (5'h17 - lead);
        if (value == 24'h000000) begin
            // Zero has an all-zero pattern
            result = 32'h00000000;
        end else begin
            // Implied one dropped, exponent biased
            result = {1'b0, `FMR_FLOAT_BIAS + {3'h0, lead},
                      norm[22:0]};
        end
    end
endmodule

// *** design/fmr_register_map.v ***
`timescale 1ns/100ps
`include "fmr_defs.vh"

module fmr_register_map (
    mclk,
    rst_b,
    regAddr,
    regRd,
    regWr,
    regWrData,
    regRdData,
    regAck,
    regReject,
    rateWr,
    rateStream,
    rateKind,
    rateData,
    accValid,
    accStream,
    accKind,
    accAmount,
    secTick,
    updTimeout,
    compSource,
    compQueryStream,
    compQueryWord,
    compQueryData,
    compUseKeypad,
    commonTimeoutAlarm,
    streamTimeoutAlarm
);
    input wire mclk;                // 20 MHz clock
    input wire rst_b;               // Asynchronous reset, active low
    input wire [15:0] regAddr;      // Register number
    input wire regRd;               // Read strobe
    input wire regWr;               // Write strobe
    input wire [15:0] regWrData;    // Write word
    output reg [15:0] regRdData;    // Read word
    output reg regAck;              // Access done
    output reg regReject;           // Access refused
    input wire rateWr;              // Flow rate update
    input wire [3:0] rateStream;    // Stream 0..11
    input wire [1:0] rateKind;      // Volume, mass, energy
    input wire [31:0] rateData;     // Float rate
    input wire accValid;            // Total increment
    input wire [1:0] accStream;     // Virtual stream 0..3
    input wire [2:0] accKind;       // Total kind 0..5
    input wire [23:0] accAmount;    // Increment, whole units
    input wire secTick;             // Timeout counting tick
    input wire [15:0] updTimeout;   // Update timeout limit
    input wire [1:0] compSource;    // Composition source
    input wire [2:0] compQueryStream; // Stream asking
    input wire [5:0] compQueryWord; // Word in its layout
    output reg [15:0] compQueryData; // Composition word
    output reg compUseKeypad;       // Keypad value must be used
    output reg commonTimeoutAlarm;  // Common range stale
    output reg [7:0] streamTimeoutAlarm; // Per-stream stale

    integer i;
    genvar g;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [15:0] rwMem [0:`FMR_RW_WORDS-1]; // Read-write words
    reg [31:0] rateMem [0:35];       // Rates, stream*3+kind
    reg [23:0] totMem [0:23];        // Totals, vstream*6+kind
    reg [15:0] cgTmo;                // Common timeout counter
    reg [15:0] psTmo [0:7];          // Per-stream counters

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire [3:0] vsHit;                // Virtual stream block hit
    wire [7:0] psHit;                // Per-stream block hit
    wire inFr;                       // Quick flow table
    wire inRwArea;                   // Barometer to per-stream end
    wire inDt;                       // Date block
    wire inCg;                       // Common components
    wire [15:0] frOff;               // Offset in flow table
    wire [8:0] rwIdx;                // Index into rwMem
    reg [1:0] vsIdx;                 // Virtual stream number
    reg [15:0] vsBase;               // Its first register
    reg [2:0] psIdx;                 // Physical stream number
    reg [15:0] psBase;               // Its first register
    wire [15:0] vsWord16;
    wire [15:0] psWord16;
    wire [5:0] vsWord;               // Word in virtual block
    wire [5:0] psWord;               // Word in per-stream block

    // Block hit per virtual and physical stream
    generate
        for (g = 0; g < 8; g = g + 1) begin : gHit
            localparam [15:0] PLO = `FMR_PS_BASE + g * `FMR_PS_STRIDE;
            localparam [15:0] PHI = PLO + `FMR_PS_STRIDE;
            assign psHit[g] = (regAddr >= PLO) && (regAddr < PHI);
            if (g < 4) begin : gVs
                localparam [15:0] VLO = `FMR_VS_BASE +
                                        g * `FMR_VS_STRIDE;
                localparam [15:0] VHI = VLO + `FMR_VS_STRIDE;
                assign vsHit[g] = (regAddr >= VLO) && (regAddr < VHI);
            end
        end
    endgenerate

    // Encode hit vectors into stream number and base
    always @* begin
        vsIdx = 2'h0;
        vsBase = `FMR_VS_BASE;
        psIdx = 3'h0;
        psBase = `FMR_PS_BASE;
        for (i = 0; i < 8; i = i + 1) begin
            if (i < 4 && vsHit[i]) begin
                vsIdx = i[1:0];
                vsBase = `FMR_VS_BASE + i[15:0] * `FMR_VS_STRIDE;
            end
            if (psHit[i]) begin
                psIdx = i[2:0];
                psBase = `FMR_PS_BASE + i[15:0] * `FMR_PS_STRIDE;
            end
        end
    end

    assign vsWord16 = regAddr - vsBase;
    assign psWord16 = regAddr - psBase;
    assign vsWord = vsWord16[5:0];
    assign psWord = psWord16[5:0];
    // Flow table spans 72 words
    assign inFr = (regAddr >= `FMR_FR_BASE) && (regAddr < `FMR_FR_END);
    assign frOff = regAddr - `FMR_FR_BASE;
    assign inDt = (regAddr >= `FMR_DT_BASE) && (regAddr < `FMR_DT_END);
    // Common range is 44 words ahead of its counter
    assign inCg = (regAddr >= `FMR_CG_BASE) && (regAddr < `FMR_CG_TMO);
    // Gap between date block and stream 0 is unmapped
    assign inRwArea = (regAddr >= `FMR_BARO) &&
                      (regAddr < `FMR_PS_END) &&
                      (inDt || regAddr < `FMR_DT_END ||
                       psHit != 8'h00);
    wire [15:0] rwIdx16 = regAddr - `FMR_BARO;
    assign rwIdx = rwIdx16[8:0];

    // ----------------------------------------
    // Date range check
    // ----------------------------------------
    // Fields outside their calendar range are refused
    function dtOk;
        input [2:0] ofs;
        input [15:0] d;
        begin
            case (ofs)
                3'h0, 3'h1: dtOk = d[15:8] <= 8'h3b && d[7:0] <= 8'h3b;
                3'h2: dtOk = d[15:8] <= 8'h17 && d[7:0] <= 8'h17;
                3'h3: dtOk = d[15:8] >= 8'h01 && d[15:8] <= 8'h1f &&
                             d[7:0] >= 8'h01 && d[7:0] <= 8'h07;
                3'h4: dtOk = d[15:8] <= 8'h63 &&
                             d[7:0] >= 8'h01 && d[7:0] <= 8'h0c;
                default: dtOk = 1'b0;
            endcase
        end
    endfunction

    wire [15:0] dtOfs16 = regAddr - `FMR_DT_BASE;

    // ----------------------------------------
    // Write classification
    // ----------------------------------------
    wire wrCgTmo = regWr && regAddr == `FMR_CG_TMO;
    wire wrPsTmo = regWr && psHit != 8'h00 &&
                   psWord == `FMR_PS_TMO_OFS;
    wire wrPsUnused = regWr && psHit != 8'h00 &&
                      psWord == `FMR_PS_UNUSED;
    wire wrDtBad = regWr && inDt && !dtOk(dtOfs16[2:0], regWrData);
    // Plain store into rwMem
    wire wrMem = regWr && inRwArea && !wrCgTmo && !wrPsTmo &&
                 !wrPsUnused && !wrDtBad;
    // Update of a component block clears its counter
    wire cgClear = wrMem && inCg;
    wire [7:0] psClear = (wrMem && psWord < `FMR_PS_TMO_OFS) ?
                         psHit : 8'h00;

    // ----------------------------------------
    // Read-write store
    // ----------------------------------------
    // Barometer, common, date and stream words
    always @(posedge mclk) begin
        if (wrMem) begin
            rwMem[rwIdx] <= regWrData;
        end
    end

    // ----------------------------------------
    // Timeout counters and alarms
    // ----------------------------------------
    // Common counter: write, clear, saturating count
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cgTmo <= `FMR_TMO_RESET;
            commonTimeoutAlarm <= 1'b0;
        end else begin
            if (wrCgTmo) begin
                cgTmo <= regWrData;
            end else if (cgClear) begin
                // Tick in the clear cycle is kept
                cgTmo <= secTick ? 16'h0001 : `FMR_TMO_RESET;
            end else if (secTick && cgTmo != `FMR_TMO_MAX) begin
                cgTmo <= cgTmo + 16'h0001;
            end
            commonTimeoutAlarm <= cgTmo > updTimeout;
        end
    end

    // Per-stream counter at offset 52 of each block
    generate
        for (g = 0; g < 8; g = g + 1) begin : gTmo
            always @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    psTmo[g] <= `FMR_TMO_RESET;
                    streamTimeoutAlarm[g] <= 1'b0;
                end else begin
                    if (wrPsTmo && psHit[g]) begin
                        psTmo[g] <= regWrData;
                    end else if (psClear[g]) begin
                        // Clear wins, tick still counted
                        psTmo[g] <= secTick ? 16'h0001 : `FMR_TMO_RESET;
                    end else if (secTick && psTmo[g] != `FMR_TMO_MAX) begin
                        psTmo[g] <= psTmo[g] + 16'h0001;
                    end
                    // Stale block raises its alarm
                    streamTimeoutAlarm[g] <= psTmo[g] > updTimeout;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Flow rates and cumulative totals
    // ----------------------------------------
    wire [5:0] rateIdx = {2'h0, rateStream} * 6'h03 + {4'h0, rateKind};
    wire [4:0] accIdx = {3'h0, accStream} * 5'h06 + {2'h0, accKind};
    wire [25:0] accSum = {2'h0, totMem[accIdx]} + {2'h0, accAmount};
    wire [25:0] accOnce = (accSum >= `FMR_TOTAL_WRAP) ?
                          accSum - `FMR_TOTAL_WRAP : accSum;
    wire [25:0] accWrap = (accOnce >= `FMR_TOTAL_WRAP) ?
                          accOnce - `FMR_TOTAL_WRAP : accOnce;

    // Rate table and wrapping totals
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (i = 0; i < 36; i = i + 1) begin
                rateMem[i] <= 32'h00000000;
            end
            for (i = 0; i < 24; i = i + 1) begin
                totMem[i] <= 24'h000000;
            end
        end else begin
            if (rateWr && rateStream < 4'hc && rateKind != 2'h3) begin
                rateMem[rateIdx] <= rateData;
            end
            if (accValid && accKind < 3'h6) begin
                totMem[accIdx] <= accWrap[23:0];
            end
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    reg [4:0] totSel;               // Total picked by address
    reg [31:0] vsFloat;             // Float under virtual address
    reg [15:0] next_regRdData;
    reg readOk;                     // Address answers a read
    wire [31:0] totFloat;           // Picked total as float
    wire [5:0] vsRateIdx = (6'h08 + {4'h0, vsIdx}) * 6'h03 +
                           {3'h0, vsWord[3:1]};
    wire [5:0] totOff = (vsWord < `FMR_VS_TOT_END) ?
                        vsWord - `FMR_VS_TOT_OFS :
                        vsWord - `FMR_VS_PREM_OFS + 6'h06;

    // Totals turned to float on the fly
    fmr_int_to_float uConv (
        .value(totMem[totSel]),
        .result(totFloat)
    );

    // Virtual block layout: rates, totals, premium
    always @* begin
        totSel = {3'h0, vsIdx} * 5'h06 + {2'h0, totOff[3:1]};
        if (vsWord < `FMR_VS_RATE_END) begin
            vsFloat = rateMem[vsRateIdx];
        end else if (vsWord < `FMR_VS_TOT_END ||
                     (vsWord >= `FMR_VS_PREM_OFS &&
                      vsWord < `FMR_VS_PREM_END)) begin
            vsFloat = totFloat;
        end else begin
            // Unlisted words read as zero
            vsFloat = 32'h00000000;
        end
    end

    // Word select; even register holds the high half
    always @* begin
        next_regRdData = 16'h0000;
        readOk = 1'b1;
        if (vsHit != 4'h0) begin
            next_regRdData = vsWord[0] ? vsFloat[15:0] : vsFloat[31:16];
        end else if (inFr) begin
            next_regRdData = frOff[0] ? rateMem[frOff[6:1]][15:0] :
                             rateMem[frOff[6:1]][31:16];
        end else if (regAddr == `FMR_CG_TMO) begin
            next_regRdData = cgTmo;
        end else if (psHit != 8'h00 && psWord == `FMR_PS_TMO_OFS) begin
            next_regRdData = psTmo[psIdx];
        end else if (psHit != 8'h00 && psWord == `FMR_PS_UNUSED) begin
            next_regRdData = 16'h0000;
        end else if (inRwArea) begin
            next_regRdData = rwMem[rwIdx];
        end else begin
            readOk = 1'b0;
        end
    end

    // Bus answer one cycle after the strobe
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            regRdData <= 16'h0000;
            regAck <= 1'b0;
            regReject <= 1'b0;
        end else begin
            regAck <= regRd || regWr;
            if (regWr) begin
                // Read-only, unmapped or out of range refused
                regReject <= !(inRwArea && !wrDtBad);
            end else if (regRd) begin
                regReject <= !readOk;
                regRdData <= readOk ? next_regRdData : 16'h0000;
            end else begin
                regReject <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Composition for the calculation
    // ----------------------------------------
    wire [8:0] psQueryIdx = `FMR_RW_PS_IDX +
                            {6'h00, compQueryStream} * 9'h036 +
                            {3'h0, compQueryWord};
    wire [8:0] cgQueryIdx = `FMR_RW_CG_IDX + {3'h0, compQueryWord};

    // Source select, common shared by all streams
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            compQueryData <= 16'h0000;
            compUseKeypad <= 1'b1;
        end else begin
            case (compSource)
                `FMR_SRC_COMMON: begin
                    compQueryData <= (compQueryWord < `FMR_CG_WORDS) ?
                                     rwMem[cgQueryIdx] : 16'h0000;
                    compUseKeypad <= commonTimeoutAlarm;
                end
                `FMR_SRC_STREAM: begin
                    compQueryData <= (compQueryWord < `FMR_PS_TMO_OFS) ?
                                     rwMem[psQueryIdx] : 16'h0000;
                    // Stale stream falls back to keypad
                    compUseKeypad <= streamTimeoutAlarm[compQueryStream];
                end
                default: begin
                    compQueryData <= 16'h0000;
                    compUseKeypad <= 1'b1;
                end
            endcase
        end
    end
endmodule

// *** verification/fmr_chk.sv ***
`timescale 1ns/100ps
// --------------------
// Port checker for the register map
// --------------------
module fmr_chk (
    input wire mclk,
    input wire rst_b,
    input wire [15:0] regAddr,
    input wire regRd,
    input wire regWr,
    input wire [15:0] regWrData,
    input wire [15:0] regRdData,
    input wire regAck,
    input wire regReject,
    input wire [15:0] updTimeout,
    input wire [1:0] compSource,
    input wire [2:0] compQueryStream,
    input wire compUseKeypad,
    input wire commonTimeoutAlarm,
    input wire [7:0] streamTimeoutAlarm
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Any access strobe
    wire anyAcc = regRd | regWr;
    // Common components
    wire cgHit = (regAddr >= 16'h0332) && (regAddr < 16'h035e);

    chk_ack_after_req: assert property (anyAcc |=> regAck)
        else $error("no ack");
    chk_no_spurious: assert property (!anyAcc |=>
        !regAck and !regReject)
        else $error("stray ack");
    chk_ro_write_refused: assert property (regWr &&
        regAddr >= 16'h01e0 && regAddr < 16'h0330 |=> regReject)
        else $error("read-only write");
    chk_unmapped_read: assert property (regRd && !regWr &&
        (regAddr < 16'h01e0 || regAddr > 16'h0515)
        |=> regReject && regRdData == 16'h0000)
        else $error("unmapped read");
    chk_rw_write_taken: assert property (regWr &&
        regAddr >= 16'h0330 && regAddr < 16'h035f |=> !regReject)
        else $error("write refused");
    chk_month_range: assert property (regWr &&
        regAddr == 16'h0363 && regWrData[7:0] > 8'h0c |=> regReject)
        else $error("bad month taken");
    chk_update_clears: assert property (regWr && cgHit &&
        updTimeout != 16'h0000 |=> ##1 !commonTimeoutAlarm)
        else $error("alarm not cleared");
    chk_keypad_common: assert property (compSource == 2'h1
        |=> compUseKeypad == $past(commonTimeoutAlarm))
        else $error("common flag");
    chk_keypad_stream: assert property (compSource == 2'h2
        |=> compUseKeypad ==
        $past(streamTimeoutAlarm[compQueryStream]))
        else $error("stream flag");
    chk_keypad_source: assert property ((compSource == 2'h0 ||
        compSource == 2'h3) |=> compUseKeypad)
        else $error("keypad flag");
endmodule

// *** verification/fmr_master.sv ***
`timescale 1ns/100ps
// --------------------
// Register master model
// --------------------
module fmr_master (
    input wire mclk,
    input wire regAck,
    input wire regReject,
    input wire [15:0] regRdData,
    output logic [15:0] regAddr,
    output logic regRd,
    output logic regWr,
    output logic [15:0] regWrData
);
    // Idle bus at time zero
    initial begin
        regAddr = 16'h0000;
        regRd = 1'b0;
        regWr = 1'b0;
        regWrData = 16'h0000;
    end
    // One access, bounded wait for acknowledge
    task automatic xfer(input logic w, input logic [15:0] a,
        input logic [15:0] d, output logic [15:0] q,
        output logic rej, output logic ok);
        int n;
        @(posedge mclk);
        #1;
        regAddr = a;
        regWrData = d;
        regRd = !w;
        regWr = w;
        @(posedge mclk);
        #1;
        regRd = 1'b0;
        regWr = 1'b0;
        // Released lines show the inverse
        regAddr = ~a;
        regWrData = ~d;
        ok = 1'b0;
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge mclk);
            ok = (regAck === 1'b1);
        end
        q = regRdData;
        rej = regReject;
        #1;
    endtask
endmodule

// *** verification/test_fmr_register_map.sv ***
`timescale 1ns/100ps
// --------------------
// Bench for the register map
// --------------------
module test_fmr_register_map;
    logic mclk, rst_b, rateWr, accValid, secTick, compUseKeypad;
    logic regRd, regWr, regAck, regReject, commonTimeoutAlarm;
    logic [15:0] regAddr, regWrData, regRdData, updTimeout;
    logic [15:0] compQueryData;
    logic [3:0] rateStream;
    logic [1:0] rateKind, accStream, compSource;
    logic [31:0] rateData;
    logic [2:0] accKind, compQueryStream;
    logic [23:0] accAmount;
    logic [5:0] compQueryWord;
    logic [7:0] streamTimeoutAlarm;
    int checked, failures, i, s, k;
    // Expected floats of 1..6
    logic [31:0] fl [6] = '{32'h3f800000, 32'h40000000, 32'h40400000,
        32'h40800000, 32'h40a00000, 32'h40c00000};

    fmr_register_map dut (.mclk, .rst_b, .regAddr, .regRd, .regWr,
        .regWrData, .regRdData, .regAck, .regReject, .rateWr,
        .rateStream, .rateKind, .rateData, .accValid, .accStream,
        .accKind, .accAmount, .secTick, .updTimeout, .compSource,
        .compQueryStream, .compQueryWord, .compQueryData,
        .compUseKeypad, .commonTimeoutAlarm, .streamTimeoutAlarm);
    fmr_master m (.mclk, .regAck, .regReject, .regRdData, .regAddr,
        .regRd, .regWr, .regWrData);

    // --------------------
    // Tasks
    // --------------------
    task automatic conclude;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Compare and count
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Checked access
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [15:0] d, input logic er);
        logic [15:0] q;
        logic rj, ok;
        m.xfer(w, a, d, q, rj, ok);
        if (!ok) begin
            failures++;
            conclude();
        end
        if (!w)
            cmp(q, d);
        cmp(rj, er);
    endtask
    // Float read, high word first
    task automatic rdf(input logic [15:0] a, input logic [31:0] v);
        acc(1'b0, a, v[31:16], 1'b0);
        acc(1'b0, a + 16'h0001, v[15:0], 1'b0);
    endtask
    // Total increment pulse
    task automatic tot(input logic [1:0] vs, input logic [2:0] kd,
        input logic [23:0] n);
        @(posedge mclk);
        #1;
        accStream = vs;
        accKind = kd;
        accAmount = n;
        accValid = 1'b1;
        @(posedge mclk);
        #1;
        accValid = 1'b0;
    endtask
    // Composition query
    task automatic qry(input logic [1:0] src, input logic [2:0] st,
        input logic [5:0] w, input logic [15:0] d, input logic kp);
        @(posedge mclk);
        #1;
        compSource = src;
        compQueryStream = st;
        compQueryWord = w;
        @(posedge mclk);
        #1;
        cmp(compQueryData, d);
        cmp(compUseKeypad, kp);
    endtask

    // Free-running clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // --------------------
    // Main sequence
    // --------------------
    initial begin
        {rst_b, rateWr, accValid, secTick, rateStream, rateKind} = '0;
        {accStream, accKind, accAmount, rateData, compSource} = '0;
        {compQueryStream, compQueryWord} = '0;
        updTimeout = 16'h0002;
        checked = 0;
        failures = 0;
        repeat (5) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        // Common range, seen by every stream
        for (i = 0; i < 44; i++) begin
            acc(1'b1, 16'(16'h0332 + i), 16'(16'hc000 + i), 1'b0);
            acc(1'b0, 16'(16'h0332 + i), 16'(16'hc000 + i), 1'b0);
            qry(2'h1, 3'(i), 6'(i), 16'(16'hc000 + i), 1'b0);
        end
        qry(2'h1, 3'h0, 6'h2c, 16'h0000, 1'b0);
        $display("test common range done");
        // Per-stream blocks
        for (s = 0; s < 8; s++) begin
            k = 16'h0366 + 16'h0036 * s;
            acc(1'b1, 16'(k), 16'(16'ha000 + s), 1'b0);
            acc(1'b1, 16'(k + 51), 16'(16'hb000 + s), 1'b0);
            acc(1'b1, 16'(k + 53), 16'hffff, 1'b0);
            acc(1'b0, 16'(k + 53), 16'h0000, 1'b0);
            acc(1'b1, 16'(k + 52), 16'h0005, 1'b0);
            acc(1'b0, 16'(k + 52), 16'h0005, 1'b0);
        end
        cmp(streamTimeoutAlarm, 8'hff);
        for (s = 0; s < 8; s++)
            qry(2'h2, 3'(s), 6'h33, 16'(16'hb000 + s), 1'b1);
        acc(1'b1, 16'h0366 + 16'h00a3, 16'h1111, 1'b0);
        cmp(streamTimeoutAlarm, 8'hf7);
        qry(2'h2, 3'h3, 6'h00, 16'ha003, 1'b0);
        $display("test stream blocks done");
        // Refused places, then the barometer word
        acc(1'b1, 16'h01e0, 16'h1234, 1'b1);
        acc(1'b1, 16'h02cf, 16'h1234, 1'b1);
        acc(1'b0, 16'h01df, 16'h0000, 1'b1);
        acc(1'b0, 16'h02d0, 16'h0000, 1'b1);
        acc(1'b0, 16'h0364, 16'h0000, 1'b1);
        acc(1'b0, 16'h0516, 16'h0000, 1'b1);
        acc(1'b1, 16'h0330, 16'h4120, 1'b0);
        acc(1'b1, 16'h0331, 16'h0000, 1'b0);
        rdf(16'h0330, 32'h41200000);
        // Calendar ranges
        acc(1'b1, 16'h0363, 16'h630c, 1'b0);
        acc(1'b1, 16'h0363, 16'h630d, 1'b1);
        acc(1'b1, 16'h0363, 16'h640c, 1'b1);
        acc(1'b1, 16'h0363, 16'h6300, 1'b1);
        acc(1'b1, 16'h0362, 16'h1f07, 1'b0);
        acc(1'b1, 16'h0362, 16'h0007, 1'b1);
        acc(1'b1, 16'h035f, 16'h3b3b, 1'b0);
        acc(1'b1, 16'h035f, 16'h3c00, 1'b1);
        acc(1'b1, 16'h0361, 16'h1718, 1'b1);
        acc(1'b0, 16'h0363, 16'h630c, 1'b0);
        acc(1'b0, 16'h035f, 16'h3b3b, 1'b0);
        $display("test refusals and calendar done");
        // Totals: wrap and placement
        tot(2'h3, 3'h0, 24'h98967f);
        rdf(16'h0264, 32'h4b18967f);
        tot(2'h3, 3'h0, 24'h000002);
        rdf(16'h0264, 32'h3f800000);
        for (k = 0; k < 6; k++)
            tot(2'h1, 3'(k), 24'(k + 1));
        tot(2'h1, 3'h6, 24'h000009);
        for (k = 0; k < 6; k++)
            rdf(16'(16'h0210 + 2 * k + (k > 2 ? 12 : 0)), fl[k]);
        acc(1'b0, 16'h0216, 16'h0000, 1'b0);
        rdf(16'h023a, 32'h00000000);
        // Rates, both tables
        for (s = 8; s < 12; s += 3) begin
            for (k = 0; k < 3; k++) begin
                @(posedge mclk);
                #1;
                rateStream = 4'(s);
                rateKind = 2'(k);
                rateData = 32'(32'h41000000 + 16 * s + k);
                rateWr = 1'b1;
                @(posedge mclk);
                #1;
                rateWr = 1'b0;
                rdf(16'(16'h0288 + 6 * s + 2 * k), rateData);
                rdf(16'(16'h01e0 + 42 * (s - 8) + 2 * k), rateData);
            end
        end
        $display("test totals and rates done");
        // Common counter and alarm
        acc(1'b1, 16'h035e, 16'h0000, 1'b0);
        @(posedge mclk);
        #1;
        secTick = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        secTick = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        cmp(commonTimeoutAlarm, 1'b1);
        acc(1'b0, 16'h035e, 16'h0003, 1'b0);
        qry(2'h1, 3'h5, 6'h00, 16'hc000, 1'b1);
        acc(1'b1, 16'h0332, 16'hc000, 1'b0);
        acc(1'b0, 16'h035e, 16'h0000, 1'b0);
        cmp(commonTimeoutAlarm, 1'b0);
        qry(2'h1, 3'h5, 6'h00, 16'hc000, 1'b0);
        qry(2'h0, 3'h0, 6'h00, 16'h0000, 1'b1);
        qry(2'h3, 3'h0, 6'h00, 16'h0000, 1'b1);
        $display("test timeout done");
        conclude();
    end
endmodule

bind fmr_register_map fmr_chk chk (.mclk, .rst_b, .regAddr, .regRd,
    .regWr, .regWrData, .regRdData, .regAck, .regReject, .updTimeout,
    .compSource, .compQueryStream, .compUseKeypad,
    .commonTimeoutAlarm, .streamTimeoutAlarm);
